/* File: design/accum_alert_map.svh */
`ifndef ACCUM_ALERT_MAP_SVH
`define ACCUM_ALERT_MAP_SVH

// register addresses on the internal register port
`define ACC_SRC_ADDR 8'h25
`define ALARM_FLAGS_ADDR 8'h26
`define ADDR_W 8

// widths and reset values
`define ACC_SRC_W 8
`define ALARM_FLAGS_W 24
`define ACC_SRC_RESET 8'h00
`define ALARM_FLAGS_RESET 24'h000000
`define RD_DATA_ZERO 24'h000000

// accumulator source field positions, channel 1 in the top field
`define CH1_SRC_LSB 6
`define CH2_SRC_LSB 4
`define CH3_SRC_LSB 2
`define CH4_SRC_LSB 0
`define SRC_FIELD_W 2

// alarm flag layout
`define FLAG_LIMIT_LSB 4
`define FLAG_LIMIT_W 20
`define FLAG_ACCUM_FULL 3
`define FLAG_TALLY_FULL 2
`define CHANNELS 4

`endif

/* File: design/accum_alert_pkg.sv */
package accum_alert_pkg;

    // accumulated quantity for one channel
    typedef enum logic [1:0] {
        SRC_POWER = 2'b00,
        SRC_SENSE = 2'b01,
        SRC_BUS = 2'b10,
        SRC_RESERVED = 2'b11
    } accum_source_t;

    // read-then-clear tracking, gray along idle -> armed
    typedef enum logic [1:0] {
        CLR_IDLE = 2'b00,
        CLR_ARMED = 2'b01
    } clr_state_t;

endpackage

/* File: design/alarm_flag_cell.sv */
`timescale 1ns/1ns
module alarm_flag_cell (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // flag control
    input wire logic setEvt,
    input wire logic holdCond,
    input wire logic clearNow,
    // sticky flag
    output logic flag
);

    logic flag_ff;
    logic nxt_flag;

    // set beats clear; a cleared bit keeps a still-present condition
    always_comb begin
        nxt_flag = flag_ff;
        if (setEvt) begin
            nxt_flag = 1'b1;
        end else if (clearNow) begin
            nxt_flag = holdCond; // see [R8]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag = flag_ff;

endmodule

/* File: design/accum_mode_alert_status.sv */
`timescale 1ns/1ns
`include "accum_alert_map.svh"
// Summary of operation
// [R1] bits 7-6 pick channel 1 accumulated quantity
// [R2] bits 5-4 pick channel 2 accumulated quantity
// [R3] bits 3-2 pick channel 3 accumulated quantity
// [R4] bits 1-0 pick channel 4 accumulated quantity
// [R5] reserved code 11 reads back zero
// [R6] source register resets to all zero
// [R7] flags clear after read plus cycle end
// [R8] still-present condition keeps flag set
// [R9] status readable live, no refresh needed
// [R10] limit alarms stay off until host enables
// [R11] bits 23-20 overcurrent, channels 1 to 4
// [R12] bits 19-16 undercurrent, channels 1 to 4
// [R13] bits 15-12 overvoltage, 11-8 undervoltage
// [R14] 7-4 overpower, 3 accum, 2 tally, 1-0 zero
// [R15] accumulator overflow or limit sets bit 3
// [R16] count overflow or limit sets bit 2
// [R17] limits checked at channel conversion completion
module accum_mode_alert_status
    import accum_alert_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port from the serial front end
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [`ACC_SRC_W-1:0] regWrData,
    input wire logic regRead,
    output logic [`ALARM_FLAGS_W-1:0] regRdData,
    // conversion timing, index 3 is channel 1
    input wire logic [`CHANNELS-1:0] chanConvDone,
    input wire logic cycleDone,
    // comparator results and enables, laid out as status bits 23..4
    input wire logic [`FLAG_LIMIT_W-1:0] limitCrossed,
    input wire logic [`FLAG_LIMIT_W-1:0] alarmEnable,
    // accumulator fullness levels
    input wire logic accumFull,
    input wire logic tallyFull,
    // per-channel accumulator source selection
    output accum_alert_pkg::accum_source_t ch1_accum_source,
    output accum_alert_pkg::accum_source_t ch2_accum_source,
    output accum_alert_pkg::accum_source_t ch3_accum_source,
    output accum_alert_pkg::accum_source_t ch4_accum_source,
    // live alarm flags
    output logic [`ALARM_FLAGS_W-1:0] alarmTripFlags
);

    // source register and its write path
    logic [`ACC_SRC_W-1:0] accSrc_ff;
    logic [`ACC_SRC_W-1:0] nxt_accSrc;
    logic [`ACC_SRC_W-1:0] wrClean;
    logic srcWrite;

    // registered read answer
    logic [`ALARM_FLAGS_W-1:0] rdData_ff;
    logic [`ALARM_FLAGS_W-1:0] nxt_rdData;

    // read-then-clear tracking
    clr_state_t clrState_ff;
    clr_state_t nxt_clrState;
    logic clearNow;
    logic statusRead;

    // per-bit set causes, hold levels and sticky flag state
    logic [`ALARM_FLAGS_W-1:0] flagBits;
    logic [`ALARM_FLAGS_W-1:0] setVec;
    logic [`ALARM_FLAGS_W-1:0] holdVec;

    // reserved code is stored as zero so readback and use agree
    function automatic logic [`SRC_FIELD_W-1:0] clean_src(
        input logic [`SRC_FIELD_W-1:0] code);
        clean_src = (code == SRC_RESERVED) ? SRC_POWER : code; // see [R5]
    endfunction

    // only a write to the source address touches the register
    assign srcWrite = regWrite && regAddr == `ACC_SRC_ADDR;

    // one cleaned field per channel, channel 4 in the bottom field
    genvar s;
    generate
        for (s = 0; s < `CHANNELS; s = s + 1) begin : g_src
            localparam int fieldLsb = `CH4_SRC_LSB + s * `SRC_FIELD_W;
            assign wrClean[fieldLsb +: `SRC_FIELD_W] =
                clean_src(regWrData[fieldLsb +: `SRC_FIELD_W]); // see [R5]
        end
    endgenerate

    // whole register loads at once, so no field is left half written
    always_comb begin
        nxt_accSrc = accSrc_ff;
        if (srcWrite) begin
            nxt_accSrc = wrClean; // see [R1] see [R2] see [R3] see [R4]
        end
    end

    // clears to power on every channel at power-on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accSrc_ff <= `ACC_SRC_RESET; // see [R6]
        end else begin
            accSrc_ff <= nxt_accSrc;
        end
    end

    // source outputs are slices of the register flip-flops
    assign ch1_accum_source =
        accum_source_t'(accSrc_ff[`CH1_SRC_LSB +: `SRC_FIELD_W]);
    assign ch2_accum_source =
        accum_source_t'(accSrc_ff[`CH2_SRC_LSB +: `SRC_FIELD_W]);
    assign ch3_accum_source =
        accum_source_t'(accSrc_ff[`CH3_SRC_LSB +: `SRC_FIELD_W]);
    assign ch4_accum_source =
        accum_source_t'(accSrc_ff[`CH4_SRC_LSB +: `SRC_FIELD_W]);

    // a status read arms the clear; the next cycle end performs it
    assign statusRead = regRead && regAddr == `ALARM_FLAGS_ADDR;
    assign clearNow = (clrState_ff == CLR_ARMED) && cycleDone; // see [R7]

    // arm on a status read, disarm at the cycle end that clears
    always_comb begin
        nxt_clrState = clrState_ff;
        case (clrState_ff)
            CLR_IDLE: begin
                // a cycle end with nothing armed leaves the flags alone
                if (statusRead) begin
                    nxt_clrState = CLR_ARMED;
                end
            end
            CLR_ARMED: begin
                // a read in the clearing cycle re-arms for the next end
                if (cycleDone && !statusRead) begin
                    nxt_clrState = CLR_IDLE;
                end
            end
            default: begin
                // unused code falls back to idle
                nxt_clrState = CLR_IDLE;
            end
        endcase
    end

    // starts idle, so no clear is pending at power-on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clrState_ff <= CLR_IDLE;
        end else begin
            clrState_ff <= nxt_clrState;
        end
    end

    // one sticky cell per implemented flag bit
    genvar b;
    generate
        for (b = 0; b < `ALARM_FLAGS_W; b = b + 1) begin : g_flag
            if (b >= `FLAG_LIMIT_LSB) begin : g_limit
                // channel 1 sits in the top bit of each group of four
                assign setVec[b] = chanConvDone[b % `CHANNELS]
                    && alarmEnable[b - `FLAG_LIMIT_LSB] // see [R10]
                    && limitCrossed[b - `FLAG_LIMIT_LSB]; // see [R17]
                assign holdVec[b] = alarmEnable[b - `FLAG_LIMIT_LSB]
                    && limitCrossed[b - `FLAG_LIMIT_LSB];
            end else if (b == `FLAG_ACCUM_FULL) begin : g_acc
                assign setVec[b] = accumFull; // see [R15]
                assign holdVec[b] = accumFull;
            end else if (b == `FLAG_TALLY_FULL) begin : g_tally
                assign setVec[b] = tallyFull; // see [R16]
                assign holdVec[b] = tallyFull;
            end else begin : g_unused
                // unimplemented bits never set
                assign setVec[b] = 1'b0; // see [R14]
                assign holdVec[b] = 1'b0;
            end
            if (b >= `FLAG_TALLY_FULL) begin : g_cell
                alarm_flag_cell u_cell (
                    .clk(clk),
                    .resetn(resetn),
                    .setEvt(setVec[b]), // see [R11] see [R12] see [R13]
                    .holdCond(holdVec[b]),
                    .clearNow(clearNow),
                    .flag(flagBits[b])
                );
            end else begin : g_zero
                // bits 1-0 have no cell and always read zero
                assign flagBits[b] = 1'b0; // see [R14]
            end
        end
    endgenerate

    // read mux straight off live flags, no latching snapshot
    always_comb begin
        nxt_rdData = `RD_DATA_ZERO;
        // the answer is zero unless a read is under way
        if (regRead) begin
            case (regAddr)
                `ACC_SRC_ADDR: begin
                    nxt_rdData[`ACC_SRC_W-1:0] = accSrc_ff;
                end
                `ALARM_FLAGS_ADDR: begin
                    // the same edge that reads also arms the clear
                    nxt_rdData = flagBits; // see [R9]
                end
                default: begin
                    nxt_rdData = `RD_DATA_ZERO;
                end
            endcase
        end
    end

    // read answer stands for one cycle only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_ff <= `RD_DATA_ZERO;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // outputs straight off flip-flops, here and in the cells, except flag bits 1-0 tied to zero
    assign regRdData = rdData_ff;
    assign alarmTripFlags = flagBits;

endmodule

/* File: tb/accum_alert_assertions.sv */
`timescale 1ns/1ns
module accum_alert_assertions
    import accum_alert_pkg::*;
(
    // clock, reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWrData,
    input wire logic regRead,
    input wire logic [23:0] regRdData,
    // alarm side
    input wire logic [3:0] chanConvDone,
    input wire logic cycleDone,
    input wire logic [19:0] limitCrossed,
    input wire logic [19:0] alarmEnable,
    input wire logic accumFull,
    input wire logic tallyFull,
    // outputs
    input wire accum_alert_pkg::accum_source_t ch1_accum_source,
    input wire accum_alert_pkg::accum_source_t ch2_accum_source,
    input wire accum_alert_pkg::accum_source_t ch3_accum_source,
    input wire accum_alert_pkg::accum_source_t ch4_accum_source,
    input wire logic [23:0] alarmTripFlags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // channel 1 overcurrent cause and hold level
    logic ocHit;
    logic ocLvl;
    assign ocLvl = alarmEnable[19] && limitCrossed[19];
    assign ocHit = chanConvDone[3] && ocLvl;
    // steps of a read then a cycle end
    sequence rdFlags;
        regRead && regAddr == 8'h26;
    endsequence
    sequence endQuiet;
        cycleDone && !ocLvl && !chanConvDone[3];
    endsequence
    a_flag_read: assert property (rdFlags |=>
        regRdData == $past(alarmTripFlags)) else $error("flag read");
    a_src_read: assert property (regRead && regAddr == 8'h25 |=>
        regRdData[7:6] == $past(ch1_accum_source)) else $error("src read");
    a_reserved_power: assert property (regWrite && regAddr == 8'h25
        && regWrData[1:0] == 2'h3 |=> ch4_accum_source == SRC_POWER)
        else $error("reserved code");
    a_low_zero: assert property (alarmTripFlags[1:0] == 2'h0)
        else $error("low bits");
    a_oc_set: assert property (ocHit |=> alarmTripFlags[23])
        else $error("oc set");
    a_accum_set: assert property (accumFull |=> alarmTripFlags[3])
        else $error("accum set");
    a_rise_cause: assert property ($rose(alarmTripFlags[23]) |->
        $past(ocHit) || $past(cycleDone)) else $error("rise cause");
    a_read_clear: assert property (rdFlags ##1 endQuiet |=>
        !alarmTripFlags[23]) else $error("read clear");
    a_hold_kept: assert property (rdFlags ##1 (cycleDone && ocLvl)
        |=> alarmTripFlags[23]) else $error("hold kept");
endmodule

bind accum_mode_alert_status accum_alert_assertions chk (.*);

/* File: tb/conv_engine_model.sv */
`timescale 1ns/1ns
module conv_engine_model (
    // clock
    input wire logic clk,
    // comparator side
    output logic [3:0] chanConvDone,
    output logic cycleDone,
    output logic [19:0] limitCrossed,
    output logic [19:0] alarmEnable,
    output logic accumFull,
    output logic tallyFull
);
    // quiet at time zero, alarms off until enabled
    initial begin
        chanConvDone = 4'h0;
        cycleDone = 1'b0;
        limitCrossed = 20'h00000;
        alarmEnable = 20'h00000;
        accumFull = 1'b0;
        tallyFull = 1'b0;
    end
    // levels move off the sampling edge
    task automatic levels(input logic [19:0] en, input logic [19:0] cr,
        input logic af, input logic tf);
        @(negedge clk);
        alarmEnable = en;
        limitCrossed = cr;
        accumFull = af;
        tallyFull = tf;
    endtask
    // no lead wait, so a cycle end can follow a read at once
    task automatic pulse(input logic [3:0] ch, input logic cyc);
        chanConvDone = ch;
        cycleDone = cyc;
        @(negedge clk);
        chanConvDone = 4'h0;
        cycleDone = 1'b0;
    endtask
endmodule

/* File: tb/accum_mode_alert_status_tb.sv */
`timescale 1ns/1ns
module accum_mode_alert_status_tb;
    import accum_alert_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRead = 1'b0;
    logic [23:0] regRdData, alarmTripFlags, exp;
    logic [3:0] chanConvDone;
    logic cycleDone, accumFull, tallyFull;
    logic [19:0] limitCrossed, alarmEnable;
    accum_source_t ch1_accum_source, ch2_accum_source;
    accum_source_t ch3_accum_source, ch4_accum_source;
    logic [1:0] c;
    int fail_count = 0;
    int num_checks = 0;
    accum_mode_alert_status dut (.*);
    conv_engine_model eng (.*);
    // free-running clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [23:0] e,
        input logic [23:0] got);
        num_checks++;
        if (got !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask
    // read strobe for one edge, answer lands a cycle later
    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        chk("regRdData", e, regRdData);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // run is under a hundred cycles, so this only trips on a hang
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        rd(8'h25, 24'h000000);
        rd(8'h26, 24'h000000);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            exp = (c == 2'h3) ? 24'h0 : {16'h0, {4{c}}};
            wr(8'h25, {4{c}});
            chk("accum_source", exp, {16'h0, ch1_accum_source,
                ch2_accum_source, ch3_accum_source,
                ch4_accum_source});
            rd(8'h25, exp);
        end
        wr(8'h25, 8'h1B);
        rd(8'h25, 24'h000018);
        wr(8'h26, 8'hFF);
        rd(8'h26, 24'h000000);
        rd(8'h30, 24'h000000);
        eng.levels(20'h00000, 20'hFFFFF, 1'b0, 1'b0);
        eng.pulse(4'hF, 1'b0);
        rd(8'h26, 24'h000000);
        // the status reads above left a clear armed: spend it while quiet
        eng.pulse(4'h0, 1'b1);
        // only channel 1 converts: its bit in every group
        eng.levels(20'hFFFFF, 20'hFFFFF, 1'b0, 1'b0);
        eng.pulse(4'h8, 1'b0);
        chk("alarmTripFlags", 24'h888880, alarmTripFlags);
        // a cycle end without a read must not clear
        eng.levels(20'hFFFFF, 20'h00000, 1'b0, 1'b0);
        eng.pulse(4'h0, 1'b1);
        rd(8'h26, 24'h888880);
        eng.pulse(4'h0, 1'b1);
        rd(8'h26, 24'h000000);
        eng.levels(20'hFFFFF, 20'hFFFFF, 1'b1, 1'b1);
        eng.pulse(4'hF, 1'b0);
        rd(8'h26, 24'hFFFFFC);
        eng.pulse(4'h0, 1'b1);
        rd(8'h26, 24'hFFFFFC);
        conclude();
    end
endmodule
